/* File: logic/csb_addr_channel.sv */
`timescale 1ns/100ps
`include "csb_params.svh"
module csb_addr_channel (
	input wire logic clk,
	input wire logic reset,
	input wire logic linkEnable,
	output logic fwdClockReset,
	output logic linkAttach,
	input wire logic cpuReadyIn,
	input wire logic cmdValid,
	input wire logic [1:0] cmdType,
	input wire logic [12:0] cmdData,
	output logic cmdReady,
	output logic cmdReject,
	output logic [12:0] cmdToCpu,
	output logic cmdToCpuStrobe,
	input wire logic reqFromCpuStrobe,
	input wire logic [12:0] reqFromCpu,
	input wire logic [7:0] memTop,
	input wire logic [7:0] gfxBase,
	input wire logic [7:0] gfxLimit,
	output logic routeValid,
	input wire logic routeReady,
	output logic [1:0] routeTarget,
	output logic [25:0] routeCmd,
	output logic linkOverrun
);
	csb_pkg::csb_ctl_t s_q;
	csb_pkg::csb_ctl_t s_d;

	// Link-domain state
	logic lnkRstSync1_q;
	logic lnkRstSync2_q;
	logic [12:0] riseWord_q;
	logic [25:0] lnkPair_q;
	logic lnkReqTgl_q;
	logic ackSync1_q;
	logic ackSync2_q;
	logic lnkOverrun_q;

	// FIFO wiring
	logic fifoInValid;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoOutReady;
	logic [25:0] fifoOutData;

	// Decoding helpers
	logic cmdLegal;
	logic [7:0] reqAddr;
	logic [12:0] fallWord;

	// Outputs come straight from flip-flops
	assign fwdClockReset = s_q.fwdRst;
	assign linkAttach = s_q.linkAttach;
	assign cmdReady = s_q.cmdReady;
	assign cmdReject = s_q.cmdReject;
	assign cmdToCpu = s_q.pinCmd;
	assign cmdToCpuStrobe = s_q.pinStrobe;
	assign routeValid = s_q.routeValid;
	assign routeTarget = s_q.routeTarget;
	assign routeCmd = s_q.routeCmd;
	assign linkOverrun = s_q.ovrSync2;

	// Only probe and data-movement kinds may reach the processor
	assign cmdLegal = (cmdType == `CSB_TYPE_PROBE) || (cmdType == `CSB_TYPE_MOVE);

	// Handshake crossing into the FIFO
	assign fifoInValid = (s_q.reqSync2 != s_q.reqSeen);
	assign fifoOutReady = !s_q.routeValid || routeReady;
	assign reqAddr = fifoOutData[`CSB_ADDR_HI:`CSB_ADDR_LO];

	// Inbound pins are active low; a pair whose first word is zero is idle
	assign fallWord = ~reqFromCpu;

	// Link reset: taken at once from the forwarded reset, released on strobe edges
	// The processor holds its strobe still during that reset, so entry needs no edge
	always_ff @(posedge reqFromCpuStrobe or posedge fwdClockReset) begin
		if (fwdClockReset) begin
			lnkRstSync1_q <= 1'b1;
			lnkRstSync2_q <= 1'b1;
		end else begin
			lnkRstSync1_q <= 1'b0;
			lnkRstSync2_q <= lnkRstSync1_q;
		end
	end

	// Rising-edge half of each request pair
	always_ff @(posedge reqFromCpuStrobe) begin
		riseWord_q <= ~reqFromCpu;
	end

	// Falling-edge half completes the pair and launches it to the core side
	always_ff @(negedge reqFromCpuStrobe or posedge lnkRstSync2_q) begin
		if (lnkRstSync2_q) begin
			ackSync1_q <= 1'b0;
			ackSync2_q <= 1'b0;
			lnkReqTgl_q <= 1'b0;
			lnkOverrun_q <= 1'b0;
			lnkPair_q <= '0;
		end else begin
			ackSync1_q <= s_q.ackTgl;
			ackSync2_q <= ackSync1_q;
			if (riseWord_q != `CSB_WORD_IDLE) begin
				if (lnkReqTgl_q == ackSync2_q) begin
					lnkPair_q <= {riseWord_q, fallWord};
					lnkReqTgl_q <= !lnkReqTgl_q;
				end else begin
					lnkOverrun_q <= 1'b1; // Pair lost: previous one not yet taken
				end
			end
		end
	end

	// Receive buffer between link capture and routing
	csb_fifo #(
		.WIDTH(`CSB_PAIR_W),
		.DEPTH(`CSB_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset(reset || s_q.fwdRst),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.inData(lnkPair_q),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData)
	);

	// Next-state logic for the reference-clock domain; clk is the ref clock
	always_comb begin
		s_d = s_q;
		s_d.cmdReject = 1'b0;
		// Synchronisers
		s_d.readySync1 = cpuReadyIn;
		s_d.readySync2 = s_q.readySync1;
		s_d.reqSync1 = lnkReqTgl_q;
		s_d.reqSync2 = s_q.reqSync1;
		s_d.ovrSync1 = lnkOverrun_q;
		s_d.ovrSync2 = s_q.ovrSync1;
		// Take a crossed pair once the FIFO has room
		if (fifoInValid && fifoInReady) begin
			s_d.reqSeen = s_q.reqSync2;
			s_d.ackTgl = !s_q.ackTgl;
		end
		// Routing stage
		if (fifoOutValid && fifoOutReady) begin
			s_d.routeValid = 1'b1;
			s_d.routeCmd = fifoOutData;
			if (reqAddr < memTop) begin
				s_d.routeTarget = `CSB_TGT_MEM;
			end else if ((reqAddr >= gfxBase) && (reqAddr <= gfxLimit)) begin
				s_d.routeTarget = `CSB_TGT_GFX;
			end else begin
				s_d.routeTarget = `CSB_TGT_PERIPH;
			end
		end else if (routeReady) begin
			s_d.routeValid = 1'b0;
		end
		// Outbound channel while running
		s_d.pinCmd = `CSB_PIN_IDLE;
		if (s_q.state == csb_pkg::CSB_RUN) begin
			s_d.pinStrobe = !s_q.pinStrobe;
			if (cmdValid && s_q.cmdReady) begin
				if (cmdLegal) begin
					s_d.pinCmd = ~cmdData;
				end else begin
					s_d.cmdReject = 1'b1;
				end
			end
		end else begin
			s_d.pinStrobe = `CSB_STROBE_IDLE;
		end
		// Sequencer
		unique case (s_q.state)
			csb_pkg::CSB_IDLE: begin
				if (linkEnable) begin
					s_d.linkAttach = 1'b1;
					s_d.state = csb_pkg::CSB_CONNECT;
				end
			end
			csb_pkg::CSB_CONNECT: begin
				if (s_q.readySync2) begin
					s_d.fwdRst = 1'b1;
					s_d.cnt = '0;
					s_d.state = csb_pkg::CSB_FWDRST;
				end
			end
			csb_pkg::CSB_FWDRST: begin
				if (s_q.cnt == 5'(`CSB_FWD_RST_CYC - 1)) begin
					s_d.fwdRst = 1'b0;
					s_d.cnt = '0;
					s_d.state = csb_pkg::CSB_DELAY;
				end else begin
					s_d.cnt = s_q.cnt + 5'h01;
				end
			end
			csb_pkg::CSB_DELAY: begin
				// RUN is entered one edge early so the strobe first moves on the third edge
				if (s_q.cnt == 5'(`CSB_START_DELAY_CYC - 2)) begin
					s_d.state = csb_pkg::CSB_RUN;
				end else begin
					s_d.cnt = s_q.cnt + 5'h01;
				end
			end
			csb_pkg::CSB_RUN: begin
				if (!linkEnable || !s_q.readySync2) begin
					s_d.linkAttach = 1'b0;
					s_d.fwdRst = 1'b1;
					s_d.state = csb_pkg::CSB_DISC;
				end
			end
			csb_pkg::CSB_DISC: begin
				if (!s_q.readySync2) begin
					s_d.state = csb_pkg::CSB_IDLE;
				end
			end
			default: begin
				s_d.state = csb_pkg::CSB_IDLE;
			end
		endcase
		// A forwarded reset parks strobe and pins on the very edge that raises it
		if (s_d.fwdRst) begin
			s_d.pinStrobe = `CSB_STROBE_IDLE;
			s_d.pinCmd = `CSB_PIN_IDLE;
		end
		// Commands are taken only once the strobe is running; ready drops on the edge that leaves RUN
		s_d.cmdReady = (s_d.state == csb_pkg::CSB_RUN) && (s_q.state == csb_pkg::CSB_RUN);
		// While the forwarded reset stands the crossing starts afresh
		if (s_q.fwdRst) begin
			s_d.reqSeen = 1'b0;
			s_d.ackTgl = 1'b0;
		end
	end

	// State register; reset negates the sideband outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= '{
				state: csb_pkg::CSB_IDLE,
				cnt: 5'h00,
				linkAttach: 1'b0,
				fwdRst: 1'b0,
				pinStrobe: `CSB_STROBE_IDLE,
				pinCmd: `CSB_PIN_IDLE,
				routeTarget: 2'h0,
				routeCmd: 26'h0000000,
				default: 1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	// Sequences for the start-up and running checks
	sequence strobeIdle3;
		cmdToCpuStrobe [*3];
	endsequence

	sequence firstToggle;
		!cmdToCpuStrobe;
	endsequence

	sequence stayRun;
		(s_q.state == csb_pkg::CSB_RUN) ##1 (s_q.state == csb_pkg::CSB_RUN);
	endsequence

	fwd_rst_hold_a: assert property (@(posedge clk) disable iff (reset)
		fwdClockReset |-> cmdToCpuStrobe)
	else $error("strobe moved while forwarded reset held");

	start_delay_a: assert property (@(posedge clk) disable iff (reset)
		$fell(fwdClockReset) |-> strobeIdle3 ##1 firstToggle)
	else $error("strobe did not start three cycles after release");

	reset_sideband_a: assert property (@(posedge clk)
		reset |=> (!fwdClockReset && !linkAttach))
	else $error("sideband outputs not negated by reset");

	attach_first_a: assert property (@(posedge clk) disable iff (reset)
		$rose(fwdClockReset) |-> $past(linkAttach))
	else $error("forwarded reset raised without attach");

	ready_gate_a: assert property (@(posedge clk) disable iff (reset)
		($rose(fwdClockReset) && linkAttach) |-> $past(s_q.readySync2))
	else $error("bring-up started without sampled ready");

	kind_refuse_a: assert property (@(posedge clk) disable iff (reset)
		(cmdValid && cmdReady && !cmdLegal) |=> (cmdReject && cmdToCpu == `CSB_PIN_IDLE))
	else $error("illegal command kind reached the processor");

	ddr_drive_a: assert property (@(posedge clk) disable iff (reset)
		(cmdValid && cmdReady && cmdLegal) |=> (cmdToCpu == ~$past(cmdData) && cmdToCpuStrobe != $past(cmdToCpuStrobe)))
	else $error("command not driven with a strobe edge");

	run_toggle_a: assert property (@(posedge clk) disable iff (reset)
		stayRun |-> (cmdToCpuStrobe != $past(cmdToCpuStrobe)))
	else $error("command strobe stalled while running");

	route_mem_a: assert property (@(posedge clk) disable iff (reset)
		(fifoOutValid && fifoOutReady && reqAddr < memTop) |=> (routeValid && routeTarget == `CSB_TGT_MEM))
	else $error("low address not routed to memory");

	route_gfx_a: assert property (@(posedge clk) disable iff (reset)
		(fifoOutValid && fifoOutReady && reqAddr >= memTop && reqAddr >= gfxBase && reqAddr <= gfxLimit)
		|=> (routeValid && routeTarget == `CSB_TGT_GFX))
	else $error("graphics window not routed to graphics port");

	route_periph_a: assert property (@(posedge clk) disable iff (reset)
		(fifoOutValid && fifoOutReady && reqAddr >= memTop && (reqAddr < gfxBase || reqAddr > gfxLimit))
		|=> (routeValid && routeTarget == `CSB_TGT_PERIPH))
	else $error("other address not routed to peripheral bus");

	route_hold_a: assert property (@(posedge clk) disable iff (reset)
		(routeValid && !routeReady) |=> (routeValid && $stable(routeCmd) && $stable(routeTarget)))
	else $error("routed command changed before it was taken");

	reject_idle_a: assert property (@(posedge clk) disable iff (reset)
		cmdReject |-> (cmdToCpu == `CSB_PIN_IDLE))
	else $error("refused command left data on the pins");

	fwd_rst_pins_a: assert property (@(posedge clk) disable iff (reset)
		fwdClockReset |-> (cmdToCpu == `CSB_PIN_IDLE))
	else $error("pins driven while forwarded reset held");

	attach_ready_a: assert property (@(posedge clk) disable iff (reset)
		cmdReady |-> (linkAttach && !fwdClockReset))
	else $error("commands taken without an attached link");

	detach_idle_a: assert property (@(posedge clk) disable iff (reset)
		!linkAttach |-> cmdToCpuStrobe)
	else $error("strobe moved while link detached");
endmodule

/* File: common/csb_params.svh */
`ifndef CSB_PARAMS_SVH
`define CSB_PARAMS_SVH

// Channel widths
`define CSB_CMD_W 13
`define CSB_PAIR_W 26
`define CSB_TYPE_W 2
`define CSB_FIFO_DEPTH 16

// Reference clock period and forwarded-clock start-up timing
`define CSB_CLK_PERIOD_NS 50
`define CSB_FWD_RST_NS 1000
`define CSB_FWD_RST_CYC ((`CSB_FWD_RST_NS + `CSB_CLK_PERIOD_NS - 1) / `CSB_CLK_PERIOD_NS)
`define CSB_START_DELAY_CYC 3
`define CSB_CNT_W 5

// Command kinds accepted on the outbound channel
`define CSB_TYPE_PROBE 2'h1
`define CSB_TYPE_MOVE 2'h2

// Routing targets
`define CSB_TGT_PERIPH 2'h0
`define CSB_TGT_GFX 2'h1
`define CSB_TGT_MEM 2'h2

// Address field of a received request pair (high byte)
`define CSB_ADDR_HI 25
`define CSB_ADDR_LO 18
`define CSB_ADDR_W 8

// Idle values (pins active low: all ones means nothing driven; the inverted inbound word idles at zero)
`define CSB_PIN_IDLE 13'h1fff
`define CSB_STROBE_IDLE 1'h1
`define CSB_WORD_IDLE 13'h0000

`endif

/* File: common/csb_pkg.sv */
package csb_pkg;

	// Start-up and power-management sequencer states
	typedef enum logic [5:0] {
		CSB_IDLE = 6'h01,
		CSB_CONNECT = 6'h02,
		CSB_FWDRST = 6'h04,
		CSB_DELAY = 6'h08,
		CSB_RUN = 6'h10,
		CSB_DISC = 6'h20
	} csb_state_t;

	// Whole reference-clock state of the block
	typedef struct packed {
		csb_state_t state;
		logic [4:0] cnt;
		logic linkAttach;
		logic fwdRst;
		logic pinStrobe;
		logic [12:0] pinCmd;
		logic cmdReady;
		logic cmdReject;
		logic readySync1;
		logic readySync2;
		logic reqSync1;
		logic reqSync2;
		logic reqSeen;
		logic ackTgl;
		logic ovrSync1;
		logic ovrSync2;
		logic routeValid;
		logic [1:0] routeTarget;
		logic [25:0] routeCmd;
	} csb_ctl_t;

endpackage

/* File: logic/csb_fifo.sv */
`timescale 1ns/100ps
// Synchronous FIFO with registered read data and valid/ready on both sides
module csb_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_q;
	logic [AW:0] rdPtr_q;
	logic outValid_q;
	logic [WIDTH-1:0] outData_q;
	logic empty;
	logic full;
	logic push;
	logic pop;

	// Honest flags from the pointer pair
	assign empty = (wrPtr_q == rdPtr_q);
	assign full = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
	assign push = inValid && !full;
	assign pop = !empty && (!outValid_q || outReady);
	assign inReady = !full;
	assign outValid = outValid_q;
	assign outData = outData_q;

	// Storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end

	// Pointers and the output register
	always_ff @(posedge clk) begin
		if (reset) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			outValid_q <= 1'b0;
			outData_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
				outData_q <= mem[rdPtr_q[AW-1:0]];
				outValid_q <= 1'b1;
			end else if (outReady) begin
				outValid_q <= 1'b0;
			end
		end
	end
endmodule

/* File: sim/csb_cpu_model.sv */
`timescale 1ns/100ps
// Processor side of the link: ready handshake and inbound request strobe
module csb_cpu_model (
	input wire logic clk,
	input wire logic linkAttach,
	input wire logic fwdClockReset,
	output logic cpuReadyIn,
	output logic reqFromCpuStrobe,
	output logic [12:0] reqFromCpu
);
	logic [25:0] pairQ[$];
	logic [25:0] cur;
	logic [1:0] attachDly;
	logic running;
	// Queue one request pair for the link
	task send(input logic [12:0] a, input logic [12:0] b);
		pairQ.push_back({a, b});
	endtask
	initial begin
		cpuReadyIn = 1'h0;
		reqFromCpuStrobe = 1'h1;
		reqFromCpu = 13'h1fff;
		running = 1'h0;
		attachDly = 2'h0;
	end
	// Ready follows attach after three reference cycles
	always @(posedge clk) begin
		attachDly <= {attachDly[0], linkAttach};
		cpuReadyIn <= attachDly[1];
	end
	// Park the strobe at its idle level while the forwarded reset stands
	always @(posedge fwdClockReset) begin
		running = 1'h0;
		#12;
		reqFromCpuStrobe = 1'h1;
		reqFromCpu = 13'h1fff;
	end
	// Free running strobe three cycles after release
	always @(negedge fwdClockReset) begin
		if (linkAttach === 1'h1) begin
			repeat (3) @(posedge clk);
			#3 reqFromCpuStrobe = 1'h0;
			running = 1'h1;
		end
	end
	// Pins inverted, changed mid-way between strobe edges
	always begin
		wait (running);
		cur = (pairQ.size() > 0) ? pairQ.pop_front() : 26'h0;
		reqFromCpu = ~cur[25:13];
		#3 reqFromCpuStrobe = 1'h1;
		#3 reqFromCpu = ~cur[12:0];
		#3 reqFromCpuStrobe = 1'h0;
		#3;
	end
endmodule

/* File: sim/tb_csb_addr_channel.sv */
`timescale 1ns/100ps
`include "csb_params.svh"
module tb_csb_addr_channel;
	logic clk, reset, linkEnable, cpuReadyIn, cmdValid, cmdReady, cmdReject, cmdToCpuStrobe;
	logic fwdClockReset, linkAttach, routeValid, routeReady, linkOverrun, reqFromCpuStrobe;
	logic [1:0] cmdType, routeTarget;
	logic [12:0] cmdData, cmdToCpu, reqFromCpu;
	logic [7:0] memTop, gfxBase, gfxLimit;
	logic [25:0] routeCmd;
	logic [12:0] firstQ[5] = '{13'h0200, 13'h10a0, 13'h0800, 13'h13e3, 13'h1800};
	int miscompares, samplesChecked;
	csb_addr_channel csb_addr_channel_i (.clk(clk), .reset(reset), .linkEnable(linkEnable),
		.fwdClockReset(fwdClockReset), .linkAttach(linkAttach), .cpuReadyIn(cpuReadyIn),
		.cmdValid(cmdValid), .cmdType(cmdType), .cmdData(cmdData), .cmdReady(cmdReady),
		.cmdReject(cmdReject), .cmdToCpu(cmdToCpu), .cmdToCpuStrobe(cmdToCpuStrobe),
		.reqFromCpuStrobe(reqFromCpuStrobe), .reqFromCpu(reqFromCpu), .memTop(memTop),
		.gfxBase(gfxBase), .gfxLimit(gfxLimit), .routeValid(routeValid), .routeReady(routeReady),
		.routeTarget(routeTarget), .routeCmd(routeCmd), .linkOverrun(linkOverrun));
	csb_cpu_model csb_cpu_model_i (.clk(clk), .linkAttach(linkAttach), .fwdClockReset(fwdClockReset),
		.cpuReadyIn(cpuReadyIn), .reqFromCpuStrobe(reqFromCpuStrobe), .reqFromCpu(reqFromCpu));
	initial clk = 1'h0;
	always #25 clk = ~clk;
	// Compare helpers
	task checkBit(input logic got, input logic exp);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task checkWord(input logic [25:0] got, input logic [25:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Expected routing target from the address byte
	function logic [1:0] expTarget(input logic [12:0] a);
		if (a[12:5] < memTop) return 2'h2;
		if (a[12:5] >= gfxBase && a[12:5] <= gfxLimit) return 2'h1;
		return 2'h0;
	endfunction
	task tally_and_finish;
		$display("Compares %0d, mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task testReset;
		checkBit(fwdClockReset, 1'h0);
		checkBit(linkAttach, 1'h0);
		checkWord(26'(cmdToCpu), 26'h1fff);
		checkBit(cmdToCpuStrobe, 1'h1);
		checkBit(routeValid, 1'h0);
		$display("testReset done");
	endtask
	task testBringup;
		int n;
		linkEnable = 1'h1;
		@(negedge clk);
		checkBit(linkAttach, 1'h1);
		n = 0;
		while (fwdClockReset !== 1'h1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		checkBit(fwdClockReset, 1'h1);
		n = 0;
		while (fwdClockReset === 1'h1 && n < 100) begin
			checkBit(cmdToCpuStrobe, 1'h1);
			@(negedge clk);
			n++;
		end
		checkWord(n[25:0], 26'(`CSB_FWD_RST_CYC));
		repeat (2) begin
			@(negedge clk);
			checkBit(cmdToCpuStrobe, 1'h1);
		end
		@(negedge clk);
		checkBit(cmdToCpuStrobe, 1'h0);
		@(negedge clk);
		checkBit(cmdToCpuStrobe, 1'h1);
		checkBit(cmdReady, 1'h1);
		$display("testBringup done");
	endtask
	task testCommands;
		logic prev;
		cmdValid = 1'h1;
		for (int i = 0; i < 4; i++) begin
			cmdType = 2'(i);
			cmdData = 13'h0a5c ^ 13'(i);
			prev = cmdToCpuStrobe;
			@(negedge clk);
			checkBit(cmdToCpuStrobe, ~prev);
			checkWord(26'(cmdToCpu), (i == 1 || i == 2) ? {13'h0000, ~cmdData} : 26'h1fff);
			checkBit(cmdReject, i == 0 || i == 3);
		end
		cmdValid = 1'h0;
		@(negedge clk);
		checkWord(26'(cmdToCpu), 26'h1fff);
		$display("testCommands done");
	endtask
	task testInbound;
		int n;
		routeReady = 1'h0;
		for (int i = 0; i < 5; i++) begin
			csb_cpu_model_i.send(firstQ[i], 13'h0f0f ^ 13'(i));
			repeat (12) @(negedge clk);
		end
		checkWord(routeCmd, {firstQ[0], 13'h0f0f});
		for (int i = 0; i < 5; i++) begin
			n = 0;
			while (routeValid !== 1'h1 && n < 20) begin
				@(negedge clk);
				n++;
			end
			checkWord(routeCmd, {firstQ[i], 13'h0f0f ^ 13'(i)});
			checkWord(26'(routeTarget), 26'(expTarget(firstQ[i])));
			routeReady = 1'h1;
			@(negedge clk);
			routeReady = 1'h0;
		end
		checkBit(linkOverrun, 1'h0);
		$display("testInbound done");
	endtask
	task testPowerDown;
		linkEnable = 1'h0;
		@(negedge clk);
		checkBit(linkAttach, 1'h0);
		checkBit(fwdClockReset, 1'h1);
		checkBit(cmdToCpuStrobe, 1'h1);
		checkBit(cmdReady, 1'h0);
		$display("testPowerDown done");
	endtask
	// Watchdog well beyond the expected run of about 125 cycles
	initial begin
		#100000;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		reset = 1'h1;
		linkEnable = 1'h0;
		cmdValid = 1'h0;
		cmdType = 2'h0;
		cmdData = 13'h0000;
		routeReady = 1'h0;
		memTop = 8'h40;
		gfxBase = 8'h80;
		gfxLimit = 8'h9f;
		miscompares = 0;
		samplesChecked = 0;
		repeat (20) @(negedge clk);
		reset = 1'h0;
		testReset;
		testBringup;
		testCommands;
		testInbound;
		testPowerDown;
		tally_and_finish;
	end
endmodule
